// ### rtl/fsp_core.sv
// Purpose: core end, turns a register port into link strobes
// Assumes: software never issues writes while the device stalls
// Notes: control write may request a store or load one cycle later
`timescale 1ns/1ps
`default_nettype none
module fsp_core (
    input wire logic clk,
    input wire logic resetn,
    fsp_if.core link,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata
);
    typedef struct packed {
        logic [15:0] ptr;
        logic [15:0] dpair;
        logic ctrl_wr;
        logic [7:0] ctrl_wdata;
        logic ctrl_rd;
        logic store_instr;
        logic load_instr;
        logic pend_store;
        logic pend_load;
        logic [7:0] ctrl_shadow;
        logic [7:0] load_byte;
        logic [15:0] rdata;
    } fsp_core_s;

    fsp_core_s r;
    fsp_core_s next_r;

    // command decode; writes refused while the core is halted
    always_comb begin
        next_r = r;
        next_r.ctrl_wr = 1'b0;
        next_r.ctrl_rd = 1'b1;
        next_r.store_instr = r.pend_store;
        next_r.load_instr = r.pend_load;
        next_r.pend_store = 1'b0;
        next_r.pend_load = 1'b0;
        next_r.rdata = 16'h0000;
        next_r.ctrl_shadow = link.ctrl_rdata;
        if (link.load_valid) begin
            next_r.load_byte = link.load_data;
        end
        // store follows the control write well inside the window
        // software keeps each buffer word single-written
        if (wr && !link.stall) begin
            case (addr)
                fsp_pkg::HA_PTR: next_r.ptr = wdata;
                fsp_pkg::HA_DATA: next_r.dpair = wdata;
                fsp_pkg::HA_CTRL: begin
                    next_r.ctrl_wr = 1'b1;
                    next_r.ctrl_wdata = wdata[7:0];
                    next_r.pend_store = wdata[fsp_pkg::HB_STORE];
                    next_r.pend_load = wdata[fsp_pkg::HB_LOAD];
                end
                default: begin
                    next_r.ctrl_wr = 1'b0;
                end
            endcase
        end
        // read data in the cycle after the strobe only
        if (rd) begin
            case (addr)
                fsp_pkg::HA_PTR: next_r.rdata = r.ptr;
                fsp_pkg::HA_DATA: next_r.rdata = r.dpair;
                fsp_pkg::HA_CTRL: next_r.rdata = {8'h00, r.ctrl_shadow};
                fsp_pkg::HA_STATUS:
                    next_r.rdata = {7'h00, link.stall, r.load_byte};
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign link.ctrl_wr = r.ctrl_wr;
    assign link.ctrl_wdata = r.ctrl_wdata;
    assign link.ctrl_rd = r.ctrl_rd;
    assign link.store_instr = r.store_instr;
    assign link.load_instr = r.load_instr;
    assign link.pointer = r.ptr;
    assign link.data_pair = r.dpair;
    assign rdata = r.rdata;
endmodule
`default_nettype wire

// ### rtl/fsp_dev.sv
// Purpose: self-programming controller, device end of the core link
// Assumes: core holds pointer and data pair steady around its strobes
// Notes: stall rises the cycle after the accepted store instruction
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fsp_dev #(
    parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    fsp_if.dev link,
    input wire logic eeprom_busy,
    input wire logic eeprom_write,
    input wire logic [1:0] lock_bits,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high
);
    typedef enum logic {FS_IDLE, FS_BUSY} fsp_state_e;

    typedef struct packed {
        fsp_state_e state;
        logic [4:0] ctrl;
        logic [2:0] win;
        logic op_write;
        logic [fsp_pkg::PAGE_W-1:0] page;
        logic [fsp_pkg::BUSY_W-1:0] busy_cnt;
        logic [fsp_pkg::WORDS*16-1:0] buf_data;
        logic loaded;
        logic stall;
        logic [7:0] rdata;
        logic [7:0] load_data;
        logic load_valid;
        logic erase_go;
        logic write_go;
    } fsp_dev_s;

    localparam fsp_dev_s RESET_S = '{
        state: FS_IDLE,
        ctrl: fsp_pkg::CTRL_RESET,
        win: 3'h0,
        op_write: 1'b0,
        page: '0,
        busy_cnt: '0,
        buf_data: '1,
        loaded: 1'b0,
        stall: 1'b0,
        rdata: 8'h00,
        load_data: 8'h00,
        load_valid: 1'b0,
        erase_go: 1'b0,
        write_go: 1'b0
    };

    localparam logic [fsp_pkg::BUSY_W-1:0] BUSY_LAST =
        fsp_pkg::BUSY_W'(PROG_CYCLES - 1);

    fsp_dev_s r;
    fsp_dev_s next_r;
    logic [15:0] flash_word;
    logic [fsp_pkg::WORD_W-1:0] word_idx;
    logic [fsp_pkg::PAGE_W-1:0] page_idx;
    logic [7:0] fuse_byte;

    assign word_idx = link.pointer[fsp_pkg::WORD_W:1];
    assign page_idx =
        link.pointer[fsp_pkg::WORD_W+fsp_pkg::PAGE_W:fsp_pkg::WORD_W+1];

    fsp_flash_array u_array (
        .clk(clk),
        .erase_go(r.erase_go),
        .write_go(r.write_go),
        .page(r.page),
        .page_data(r.buf_data),
        .rd_addr(link.pointer[fsp_pkg::WORD_W+fsp_pkg::PAGE_W:1]),
        .rd_data(flash_word)
    );

    // fuse or lock byte chosen by low pointer bits
    always_comb begin
        case (link.pointer[1:0])
            fsp_pkg::SEL_LOCK: fuse_byte = {6'h3f, lock_bits};
            fsp_pkg::SEL_FUSE_HIGH: fuse_byte = fuse_high;
            default: fuse_byte = fuse_low;
        endcase
    end

    // next state of the whole controller
    always_comb begin
        next_r = r;
        next_r.load_valid = 1'b0;
        next_r.erase_go = 1'b0;
        next_r.write_go = 1'b0;
        if (link.ctrl_rd) begin
            next_r.rdata = {3'h0, r.ctrl};
        end
        case (r.state)
            FS_IDLE: begin
                // buffer cleared once the page program is taken
                if (r.write_go) begin
                    next_r.buf_data = '1;
                    next_r.loaded = 1'b0;
                end
                // window countdown closes the store window
                // page write bit drops at window end
                // page erase bit drops at window end
                // enable drops after four idle cycles
                if (r.ctrl[fsp_pkg::BIT_STORE_EN]) begin
                    if (r.win <= 3'h1) begin
                        next_r.ctrl = fsp_pkg::CTRL_RESET;
                    end else begin
                        next_r.win = r.win - 3'h1;
                    end
                    // fuse read window is one cycle shorter
                    if (r.ctrl[fsp_pkg::BIT_FUSE_RD] &&
                            r.win <= fsp_pkg::FUSE_LAST) begin
                        next_r.ctrl = fsp_pkg::CTRL_RESET;
                    end
                end
                // no store takes effect while EEPROM writes
                if (link.store_instr && r.ctrl[fsp_pkg::BIT_STORE_EN] &&
                        !eeprom_busy) begin
                    case (r.ctrl)
                        fsp_pkg::CMD_ERASE: begin
                            next_r.state = FS_BUSY;
                            next_r.op_write = 1'b0;
                            next_r.page = page_idx;
                            next_r.busy_cnt = '0;
                            next_r.stall = 1'b1;
                        end
                        // program the buffer into the page
                        fsp_pkg::CMD_WRITE: begin
                            next_r.state = FS_BUSY;
                            next_r.op_write = 1'b1;
                            next_r.page = page_idx;
                            next_r.busy_cnt = '0;
                            next_r.stall = 1'b1;
                        end
                        // data pair into word, bit 0 ignored
                        fsp_pkg::CMD_LOAD: begin
                            next_r.buf_data[word_idx*16 +: 16] =
                                link.data_pair;
                            next_r.loaded = 1'b1;
                            next_r.ctrl = fsp_pkg::CTRL_RESET;
                        end
                        default: begin
                            next_r.ctrl = fsp_pkg::CTRL_RESET;
                        end
                    endcase
                end
                // program memory read, fuse read inside its window
                if (link.load_instr) begin
                    next_r.load_valid = 1'b1;
                    if (r.ctrl == fsp_pkg::CMD_FUSE && !eeprom_busy &&
                            r.win >= fsp_pkg::FUSE_LAST) begin
                        next_r.load_data = fuse_byte;
                        next_r.ctrl = fsp_pkg::CTRL_RESET;
                    end else begin
                        // byte select by pointer bit 0
                        next_r.load_data = link.pointer[0] ?
                            flash_word[15:8] : flash_word[7:0];
                    end
                end
                // only the five legal patterns take effect
                // control writes blocked while EEPROM writes
                if (link.ctrl_wr && !eeprom_busy &&
                        (link.ctrl_wdata[4:0] == fsp_pkg::CMD_LOAD ||
                         link.ctrl_wdata[4:0] == fsp_pkg::CMD_ERASE ||
                         link.ctrl_wdata[4:0] == fsp_pkg::CMD_WRITE ||
                         link.ctrl_wdata[4:0] == fsp_pkg::CMD_FUSE ||
                         link.ctrl_wdata[4:0] == fsp_pkg::CMD_CLEAR)) begin
                    next_r.ctrl = link.ctrl_wdata[4:0];
                    next_r.win = fsp_pkg::STORE_WINDOW;
                    if (link.ctrl_wdata[4:0] == fsp_pkg::CMD_CLEAR) begin
                        next_r.buf_data = '1;
                        next_r.loaded = 1'b0;
                    end
                end
                // EEPROM write loses a partly loaded page
                if (eeprom_write && r.loaded) begin
                    next_r.buf_data = '1;
                    next_r.loaded = 1'b0;
                end
            end
            FS_BUSY: begin
                // core held for the whole operation
                // duration counted from the least time
                next_r.busy_cnt = r.busy_cnt + 1'b1;
                if (r.busy_cnt == BUSY_LAST) begin
                    next_r.state = FS_IDLE;
                    next_r.stall = 1'b0;
                    next_r.erase_go = !r.op_write;
                    next_r.write_go = r.op_write;
                    // page write bit clears on completion
                    // page erase bit clears on completion
                    next_r.ctrl = fsp_pkg::CTRL_RESET;
                end
            end
            default: begin
                next_r = RESET_S;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= RESET_S;
        end else begin
            r <= next_r;
        end
    end

    // all link outputs straight from the state register
    assign link.ctrl_rdata = r.rdata;
    assign link.stall = r.stall;
    assign link.load_data = r.load_data;
    assign link.load_valid = r.load_valid;
endmodule
`default_nettype wire

// ### rtl/fsp_flash_array.sv
// Purpose: program flash array with page erase and page program
// Assumes: programming only clears bits, erase sets a page to ones
// Notes: no reset on the array; contents survive controller reset
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_array (
    input wire logic clk,
    input wire logic erase_go,
    input wire logic write_go,
    input wire logic [fsp_pkg::PAGE_W-1:0] page,
    input wire logic [fsp_pkg::WORDS*16-1:0] page_data,
    input wire logic [fsp_pkg::WORD_W+fsp_pkg::PAGE_W-1:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [fsp_pkg::FLASH_WORDS];

    // whole page updated in one edge when the timed operation ends
    always_ff @(posedge clk) begin
        for (int i = 0; i < fsp_pkg::WORDS; i++) begin
            if (erase_go) begin
                mem[{page, i[fsp_pkg::WORD_W-1:0]}] <= 16'hffff;
            end else if (write_go) begin
                mem[{page, i[fsp_pkg::WORD_W-1:0]}] <=
                    mem[{page, i[fsp_pkg::WORD_W-1:0]}] &
                    page_data[i*16 +: 16];
            end
        end
    end

    // asynchronous read, registered by the controller
    assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// ### rtl/fsp_if.sv
// Purpose: link between processor core and self-programming controller
// Assumes: both ends on one clock
// Notes: write, store and load strobes are one-cycle pulses; the core holds ctrl_rd high
`timescale 1ns/1ps
`default_nettype none
interface fsp_if;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic ctrl_rd;
    logic [7:0] ctrl_rdata;
    logic store_instr;
    logic load_instr;
    logic [15:0] pointer;
    logic [15:0] data_pair;
    logic stall;
    logic [7:0] load_data;
    logic load_valid;
    modport dev(
        input ctrl_wr, ctrl_wdata, ctrl_rd, store_instr, load_instr,
        input pointer, data_pair,
        output ctrl_rdata, stall, load_data, load_valid
    );
    modport core(
        output ctrl_wr, ctrl_wdata, ctrl_rd, store_instr, load_instr,
        output pointer, data_pair,
        input ctrl_rdata, stall, load_data, load_valid
    );
endinterface
`default_nettype wire

// ### rtl/fsp_pkg.sv
// Purpose: shared constants for the flash self-programming controller
// Assumes: 20 MHz system clock, 16-bit pointer, 16-bit flash words
// Notes: page/word split of the pointer is set here
package fsp_pkg;
    // pointer split: bit 0 byte select, then word field, then page field
    localparam int WORD_W = 4;
    localparam int PAGE_W = 6;
    localparam int PTR_W = 16;
    localparam int DATA_W = 16;
    localparam int WORDS = 1 << WORD_W;
    localparam int FLASH_WORDS = 1 << (WORD_W + PAGE_W);
    // control register bit positions
    localparam int BIT_STORE_EN = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_WRITE = 2;
    localparam int BIT_FUSE_RD = 3;
    localparam int BIT_CLR = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // the only control patterns that take effect
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_FUSE = 5'h09;
    localparam logic [4:0] CMD_CLEAR = 5'h11;
    // store window of four cycles, fuse read window of three
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] FUSE_LAST = 3'h2;
    // programming time from the timing oscillator, least time
    localparam real PROG_MIN_MS = 3.7;
    localparam real PROG_MAX_MS = 4.5;
    localparam real CLK_NS = 50.0;
    localparam int PROG_CYCLES = int'($ceil(PROG_MIN_MS * 1.0e6 / CLK_NS));
    localparam int BUSY_W = 17;
    // fuse select from the low pointer bits
    localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
    localparam logic [1:0] SEL_LOCK = 2'h1;
    localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
    // host command port
    localparam logic [2:0] HA_PTR = 3'h0;
    localparam logic [2:0] HA_DATA = 3'h1;
    localparam logic [2:0] HA_CTRL = 3'h2;
    localparam logic [2:0] HA_STATUS = 3'h3;
    localparam int HB_STORE = 8;
    localparam int HB_LOAD = 9;
endpackage

// ### testbench/fsp_link_sva.sv
// Purpose: link checker for the self-programming controller
// Assumes: core holds ctrl_rd high, so ctrl_rdata mirrors control
// Notes: ctrl_rdata lags the control register by one cycle
`timescale 1ns/1ps
`default_nettype none
module fsp_link_sva #(
    parameter int PROG_CYCLES = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic ctrl_rd,
    input wire logic [7:0] ctrl_rdata,
    input wire logic store_instr,
    input wire logic load_instr,
    input wire logic [15:0] pointer,
    input wire logic [15:0] data_pair,
    input wire logic stall,
    input wire logic [7:0] load_data,
    input wire logic load_valid
);
    logic [4:0] last_cmd;
    logic [2:0] age;
    logic [16:0] busy_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // last pattern and its age; age saturates so stale stores stand out
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_cmd <= 5'h00;
            age <= 3'h7;
            busy_cnt <= 17'h00000;
        end else begin
            if (ctrl_wr) begin
                last_cmd <= ctrl_wdata[4:0];
                age <= 3'h0;
            end else if (age != 3'h7) begin
                age <= age + 3'h1;
            end
            busy_cnt <= stall ? busy_cnt + 17'h00001 : 17'h00000;
        end
    end
    // an erase or write armed while idle, then no store for four cycles
    sequence s_arm;
        !stall && ctrl_wr &&
            (ctrl_wdata[4:0] == 5'h03 || ctrl_wdata[4:0] == 5'h05);
    endsequence
    sequence s_quiet;
        !store_instr [*4];
    endsequence
    property p_load_answer;
        load_instr |=> load_valid;
    endproperty
    property p_no_stray_valid;
        !load_instr |=> !load_valid;
    endproperty
    property p_rsvd_zero;
        ctrl_rdata[7:5] == 3'h0;
    endproperty
    property p_busy_len;
        $fell(stall) |-> busy_cnt == PROG_CYCLES;
    endproperty
    property p_busy_max;
        stall |-> busy_cnt < PROG_CYCLES;
    endproperty
    property p_busy_cause;
        $rose(stall) |-> $past(store_instr) && $past(age) <= 3'h3 &&
            ($past(last_cmd) == 5'h03 || $past(last_cmd) == 5'h05);
    endproperty
    property p_no_effect;
        store_instr && !stall &&
            (age > 3'h3 || !(last_cmd == 5'h03 || last_cmd == 5'h05))
            |=> !stall;
    endproperty
    property p_held;
        stall && $past(stall) |->
            ctrl_rdata[4:0] == 5'h03 || ctrl_rdata[4:0] == 5'h05;
    endproperty
    property p_expire;
        s_arm ##1 s_quiet |-> ##[1:3] ctrl_rdata[4:0] == 5'h00;
    endproperty
    property p_store_clear;
        store_instr && age <= 3'h3 && last_cmd == 5'h01
            |-> ##[1:5] ctrl_rdata[4:0] == 5'h00;
    endproperty
    a_load_answer: assert property (p_load_answer)
        else $error("load answer missing");
    a_no_stray_valid: assert property (p_no_stray_valid)
        else $error("load answer without request");
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("upper control bits not zero");
    a_busy_len: assert property (p_busy_len)
        else $error("stall length wrong");
    a_busy_max: assert property (p_busy_max)
        else $error("stall too long");
    a_busy_cause: assert property (p_busy_cause)
        else $error("stall without armed store");
    a_no_effect: assert property (p_no_effect)
        else $error("store took effect outside window");
    a_held: assert property (p_held)
        else $error("control dropped during operation");
    a_expire: assert property (p_expire)
        else $error("armed bits did not expire");
    a_store_clear: assert property (p_store_clear)
        else $error("enable not cleared after store");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: self-checking bench for both ends of the self-programming link
// Assumes: short programming time through PROG_CYCLES
// Notes: flash bytes are read back through the core load path
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int PC = 20;
    localparam logic [15:0] FL = 16'h0200;
    localparam logic [15:0] FZ_PTR [4] = '{16'h0, 16'h1, 16'h3, 16'h2};
    localparam logic [7:0] FZ_EXP [4] = '{8'h6c, 8'hfe, 8'hd9, 8'h6c};
    localparam logic [15:0] BAD [4] = '{16'h0102, 16'h0107, 16'h010d,
        16'h011f};
    localparam logic [15:0] ARM [2] = '{16'h0003, 16'h0005};
    logic clk;
    logic resetn;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic eeprom_busy;
    logic eeprom_write;
    logic [15:0] r;
    int errors;
    int checks_done;
    int n;
    fsp_if lnk ();
    fsp_core i_fsp_core (.clk(clk), .resetn(resetn), .link(lnk),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    fsp_dev #(.PROG_CYCLES(PC)) i_fsp_dev (.clk(clk), .resetn(resetn),
        .link(lnk), .eeprom_busy(eeprom_busy), .eeprom_write(eeprom_write),
        .lock_bits(2'h2), .fuse_low(8'h6c), .fuse_high(8'hd9));
    fsp_link_sva #(.PROG_CYCLES(PC)) i_fsp_link_sva (.clk(clk),
        .resetn(resetn), .ctrl_wr(lnk.ctrl_wr), .ctrl_wdata(lnk.ctrl_wdata),
        .ctrl_rd(lnk.ctrl_rd), .ctrl_rdata(lnk.ctrl_rdata),
        .store_instr(lnk.store_instr), .load_instr(lnk.load_instr),
        .pointer(lnk.pointer), .data_pair(lnk.data_pair), .stall(lnk.stall),
        .load_data(lnk.load_data), .load_valid(lnk.load_valid));
    // clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle strobes, launched just after an edge
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // control write plus store; counts cycles the core is held
    task automatic op(input logic [15:0] c, input logic [15:0] p,
        output int cnt);
        wr_reg(fsp_pkg::HA_PTR, p);
        wr_reg(fsp_pkg::HA_CTRL, c);
        cnt = 0;
        repeat (PC + 20) begin
            @(posedge clk);
            #1;
            if (lnk.stall === 1'b1) cnt++;
        end
    endtask
    task automatic pg(input logic [15:0] p);
        int k;
        op(16'h0103, p, k);
        chk(16'(k), 16'(PC));
        op(16'h0105, p, k);
        chk(16'(k), 16'(PC));
    endtask
    task automatic ld(input logic [15:0] p, input logic [15:0] d);
        wr_reg(fsp_pkg::HA_PTR, p);
        wr_reg(fsp_pkg::HA_DATA, d);
        wr_reg(fsp_pkg::HA_CTRL, 16'h0101);
        repeat (3) @(posedge clk);
    endtask
    // load through the core, then compare the status byte
    task automatic rck(input logic [15:0] p, input logic [15:0] c,
        input logic [7:0] e);
        logic [15:0] v;
        wr_reg(fsp_pkg::HA_PTR, p);
        wr_reg(fsp_pkg::HA_CTRL, c);
        repeat (3) @(posedge clk);
        rd_reg(fsp_pkg::HA_STATUS, v);
        chk({8'h00, v[7:0]}, {8'h00, e});
    endtask
    // watchdog, far beyond the roughly eleven hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end
    initial begin
        errors = 0;
        checks_done = 0;
        addr = 3'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        eeprom_busy = 1'b0;
        eeprom_write = 1'b0;
        resetn = 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(fsp_pkg::HA_CTRL, r);
        chk(r, 16'h0000);
        // table rows: fuse and lock selection by pointer
        for (int i = 0; i < 4; i++) begin
            rck(FZ_PTR[i], 16'h0209, FZ_EXP[i]);
        end
        // erase with a stray high pointer bit, then load out of order
        op(16'h0103, 16'h80a0, n);
        chk(16'(n), 16'(PC));
        rck(16'h00a0, FL, 8'hff);
        ld(16'h00a7, 16'h1234);
        ld(16'h00a3, 16'habcd);
        op(16'h0105, 16'h00a0, n);
        chk(16'(n), 16'(PC));
        rck(16'h00a6, FL, 8'h34);
        rck(16'h00a7, FL, 8'h12);
        rck(16'h00a3, FL, 8'hab);
        rck(16'h00a0, FL, 8'hff);
        // load before erase, then buffer must be empty after the write
        ld(16'h00c0, 16'h5a5a);
        pg(16'h00c0);
        rck(16'h00c0, FL, 8'h5a);
        pg(16'h00e0);
        rck(16'h00e0, FL, 8'hff);
        // clear bit discards a loaded word
        ld(16'h0104, 16'h0f0f);
        wr_reg(fsp_pkg::HA_CTRL, 16'h0011);
        repeat (6) @(posedge clk);
        pg(16'h0100);
        rck(16'h0104, FL, 8'hff);
        // eeprom write during loading loses the buffer
        ld(16'h0124, 16'h0f0f);
        @(posedge clk);
        eeprom_write <= 1'b1;
        @(posedge clk);
        eeprom_write <= 1'b0;
        pg(16'h0120);
        rck(16'h0124, FL, 8'hff);
        // eeprom busy blocks an erase
        @(posedge clk);
        eeprom_busy <= 1'b1;
        op(16'h0103, 16'h00a0, n);
        chk(16'(n), 16'h0000);
        @(posedge clk);
        eeprom_busy <= 1'b0;
        rck(16'h00a6, FL, 8'h34);
        // armed bits expire; a late store has no effect
        for (int i = 0; i < 2; i++) begin
            wr_reg(fsp_pkg::HA_CTRL, ARM[i]);
            repeat (8) @(posedge clk);
            rd_reg(fsp_pkg::HA_CTRL, r);
            chk(r, 16'h0000);
            op(16'h0100, 16'h00a0, n);
            chk(16'(n), 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            op(BAD[i], 16'h00a0, n);
            chk(16'(n), 16'h0000);
        end
        rck(16'h00a6, FL, 8'h34);
        // reset in mid-run empties the buffer
        ld(16'h0148, 16'h1111);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        pg(16'h0140);
        rck(16'h0148, FL, 8'hff);
        report_and_stop();
    end
endmodule
`default_nettype wire
